// ### include/rmc_pkg.sv
package rmc_pkg;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_OUTPUT_OPERATION_CONTROL = 8'h01;
  localparam logic [7:0] OFS_ON_OFF_GATING_CONFIG = 8'h02;
  localparam logic [7:0] OFS_CUSTOMER_SERIAL_BLOCK = 8'h9E;
  localparam logic [7:0] OFS_DEVICE_IDENTIFIER_BLOCK = 8'hAD;
  localparam logic [7:0] OFS_BUS_BASE_ADDRESS_PRIMARY = 8'hD7;
  localparam logic [7:0] OFS_BUS_BASE_ADDRESS_SECONDARY = 8'hE2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_OUTPUT_OPERATION_CONTROL = 8'h88;
  localparam logic [7:0] RST_ON_OFF_GATING_CONFIG = 8'h1F;
  localparam logic [6:0] RST_BUS_BASE_ADDRESS_PRIMARY = 7'h10;
  localparam logic [6:0] RST_BUS_BASE_ADDRESS_SECONDARY = 7'h50;
  // arbitrary neutral value, not a real part code
  localparam logic [15:0] RST_DEVICE_IDENTIFIER = 16'h5A3C;

  // ---------------------------------------------------------------
  // field positions and writable masks
  // ---------------------------------------------------------------
  localparam int OP_ON_BIT = 7;
  localparam int OP_OFF_STYLE_BIT = 6;
  localparam int OP_MARGIN_LSB = 4;
  localparam int OP_FAULT_POLICY_LSB = 2;
  localparam logic [7:0] OP_WRITE_MASK = 8'hFC;
  localparam int CFG_POWERUP_GATING_BIT = 4;
  localparam int CFG_CMD_GATING_BIT = 3;
  localparam int CFG_PIN_GATING_BIT = 2;
  localparam int CFG_PIN_POLARITY_BIT = 1;
  localparam int CFG_PIN_OFF_STYLE_BIT = 0;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h1F;

  // ---------------------------------------------------------------
  // field encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] MARGIN_NOMINAL = 2'h0;
  localparam logic [1:0] MARGIN_LOW = 2'h1;
  localparam logic [1:0] MARGIN_HIGH = 2'h2;
  localparam logic [1:0] FAULT_POLICY_IGNORE = 2'h1;
  localparam logic [1:0] FAULT_POLICY_ACT = 2'h2;

  // ---------------------------------------------------------------
  // turn-off timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int TOFF_DELAY_NS = 1000;
  localparam int TOFF_FALL_NS = 2000;
  localparam int TOFF_DELAY_CYC = (TOFF_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int TOFF_FALL_CYC = (TOFF_FALL_NS * CLK_MHZ + 999) / 1000;

  // ---------------------------------------------------------------
  // output sequencing states
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    RMC_OFF = 2'b00,
    RMC_ON = 2'b01,
    RMC_DELAY = 2'b10,
    RMC_FALL = 2'b11
  } rmc_state_t;

endpackage

// ### rtl/rmc_timer.sv
`timescale 1ns/1ns
module rmc_timer #(
  parameter int CYCLES = 4
)(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic abort,
  output logic busy,
  output logic done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic next_done;

  // --------------------------------------------------------------
  // down counter, done pulses in the cycle the count reaches zero
  // --------------------------------------------------------------
  always_comb
  begin
    next_count = count;
    next_done = 1'b0;
    if (abort)
      next_count = '0;
    else if (start)
      next_count = LOAD;
    else if (count != '0)
    begin
      next_count = count - CW'(1);
      next_done = (count == CW'(1));
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      count <= '0;
      done <= 1'b0;
    end
    else
    begin
      count <= next_count;
      done <= next_done;
    end
  end

  assign busy = (count != '0);
endmodule

// ### rtl/rmc_control.sv
`timescale 1ns/1ns
// Summary of operation
// - operation resets 88h, bit7 commands output on
// - on bit and enable pin jointly switch output
// - bit6 zero: command-off drops output immediately
// - bit6 one: command-off runs delay then fall
// - margin 00 selects nominal setpoint; 11 unsupported
// - margin 01 selects low margin setpoint
// - margin 10 selects high margin setpoint
// - policy 01 ignores margin faults; 00 and 11 unsupported
// - policy 10 acts on margin faults normally
// - gating config resets 1Fh, selects on sources
// - powerup gating zero: convert whenever powered
// - powerup gating one: wait for selected sources
// - config bit3 ignores or obeys on bit
// - config bit2 zero ignores enable pin
// - config bit2 one requires asserted enable pin
// - config bit1 sets enable pin polarity
// - pin-off: bit0 zero sequenced, one immediate
// - host read/write customer serial block storage
module rmc_control
  import rmc_pkg::*;
#(
  parameter int SERIAL_BYTES = 16,
  parameter int DELAY_CYCLES = rmc_pkg::TOFF_DELAY_CYC,
  parameter int FALL_CYCLES = rmc_pkg::TOFF_FALL_CYC
)(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_index,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  output logic cmd_done,
  output logic cmd_err,
  input wire logic control_enable_pin,
  output logic output_enable,
  output logic fall_active,
  output logic [1:0] setpoint_select,
  output logic margin_faults_ignore,
  output logic margin_faults_act
);
  import rmc_pkg::*;

  localparam int IW = (SERIAL_BYTES > 1) ? $clog2(SERIAL_BYTES) : 1;

  // --------------------------------------------------------------
  // register state
  // --------------------------------------------------------------
  logic [7:0] output_operation_control;
  logic [7:0] on_off_gating_config;
  logic [7:0] customer_serial_block [SERIAL_BYTES];
  logic [15:0] device_identifier_block;
  logic [7:0] next_output_operation_control;
  logic [7:0] next_on_off_gating_config;
  logic [7:0] next_serial_byte;
  logic serial_we;
  logic [15:0] next_device_identifier_block;
  logic [15:0] next_cmd_rdata;
  logic next_cmd_done;
  logic next_cmd_err;
  logic serial_hit;
  logic [IW-1:0] serial_idx;

  assign serial_hit = ({24'h0, cmd_index} < 32'(SERIAL_BYTES));
  assign serial_idx = cmd_index[IW-1:0];

  // --------------------------------------------------------------
  // command decode: writes, reads and refusals
  // --------------------------------------------------------------
  always_comb
  begin
    next_output_operation_control = output_operation_control;
    next_on_off_gating_config = on_off_gating_config;
    next_device_identifier_block = device_identifier_block;
    next_serial_byte = cmd_wdata[7:0];
    serial_we = 1'b0;
    next_cmd_rdata = cmd_rdata;
    next_cmd_done = 1'b0;
    next_cmd_err = 1'b0;
    if (cmd_wr)
    begin
      next_cmd_done = 1'b1;
      case (cmd_code)
        OFS_OUTPUT_OPERATION_CONTROL:
          next_output_operation_control = cmd_wdata[7:0] & OP_WRITE_MASK;
        OFS_ON_OFF_GATING_CONFIG:
          next_on_off_gating_config = cmd_wdata[7:0] & CFG_WRITE_MASK;
        OFS_CUSTOMER_SERIAL_BLOCK:
        begin
          serial_we = serial_hit;
          next_cmd_err = !serial_hit;
        end
        OFS_DEVICE_IDENTIFIER_BLOCK:
          next_device_identifier_block = cmd_wdata;
        default:
          next_cmd_err = 1'b1; // read-only or unknown code
      endcase
    end
    else if (cmd_rd)
    begin
      next_cmd_done = 1'b1;
      case (cmd_code)
        OFS_OUTPUT_OPERATION_CONTROL:
          next_cmd_rdata = {8'h00, output_operation_control};
        OFS_ON_OFF_GATING_CONFIG:
          next_cmd_rdata = {8'h00, on_off_gating_config};
        OFS_CUSTOMER_SERIAL_BLOCK:
        begin
          next_cmd_rdata = serial_hit ? {8'h00, customer_serial_block[serial_idx]} : 16'h0000;
          next_cmd_err = !serial_hit;
        end
        OFS_DEVICE_IDENTIFIER_BLOCK:
          next_cmd_rdata = device_identifier_block;
        OFS_BUS_BASE_ADDRESS_PRIMARY:
          next_cmd_rdata = {9'h000, RST_BUS_BASE_ADDRESS_PRIMARY};
        OFS_BUS_BASE_ADDRESS_SECONDARY:
          next_cmd_rdata = {9'h000, RST_BUS_BASE_ADDRESS_SECONDARY};
        default:
        begin
          next_cmd_rdata = 16'h0000;
          next_cmd_err = 1'b1;
        end
      endcase
    end
  end

  // serial block has no defined content, so it is left out of reset
  always_ff @(posedge mclk)
  begin
    if (serial_we)
      customer_serial_block[serial_idx] <= next_serial_byte;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      output_operation_control <= RST_OUTPUT_OPERATION_CONTROL;
      on_off_gating_config <= RST_ON_OFF_GATING_CONFIG;
      device_identifier_block <= RST_DEVICE_IDENTIFIER;
      cmd_rdata <= 16'h0000;
      cmd_done <= 1'b0;
      cmd_err <= 1'b0;
    end
    else
    begin
      output_operation_control <= next_output_operation_control;
      on_off_gating_config <= next_on_off_gating_config;
      device_identifier_block <= next_device_identifier_block;
      cmd_rdata <= next_cmd_rdata;
      cmd_done <= next_cmd_done;
      cmd_err <= next_cmd_err;
    end
  end

  // --------------------------------------------------------------
  // gating sources
  // --------------------------------------------------------------
  logic pin_asserted;
  logic cmd_says_off;
  logic pin_says_off;
  logic on_request;

  assign pin_asserted = on_off_gating_config[CFG_PIN_POLARITY_BIT] ?
                        control_enable_pin : !control_enable_pin;
  // a source only counts when its gating bit selects it
  assign cmd_says_off = on_off_gating_config[CFG_CMD_GATING_BIT] &&
                        !output_operation_control[OP_ON_BIT];
  assign pin_says_off = on_off_gating_config[CFG_PIN_GATING_BIT] && !pin_asserted;
  // powerup gating clear means powered implies converting
  assign on_request = !on_off_gating_config[CFG_POWERUP_GATING_BIT] ||
                      (!cmd_says_off && !pin_says_off);

  // immediate off if any off-causing source asks for it
  logic off_immediate;
  assign off_immediate = (cmd_says_off && !output_operation_control[OP_OFF_STYLE_BIT]) ||
                         (pin_says_off && on_off_gating_config[CFG_PIN_OFF_STYLE_BIT]);

  // --------------------------------------------------------------
  // turn-off sequencing
  // --------------------------------------------------------------
  rmc_state_t state;
  rmc_state_t next_state;
  logic delay_start;
  logic fall_start;
  logic seq_abort;
  logic delay_busy;
  logic delay_done;
  logic fall_busy;
  logic fall_done;

  rmc_timer #(.CYCLES(DELAY_CYCLES)) u_delay (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(delay_start),
    .abort(seq_abort),
    .busy(delay_busy),
    .done(delay_done)
  );

  rmc_timer #(.CYCLES(FALL_CYCLES)) u_fall (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(fall_start),
    .abort(seq_abort),
    .busy(fall_busy),
    .done(fall_done)
  );

  // an on request during delay or fall resumes at once; an
  // immediate-off request cuts a running sequence short
  always_comb
  begin
    next_state = state;
    delay_start = 1'b0;
    fall_start = 1'b0;
    seq_abort = 1'b0;
    case (state)
      RMC_OFF:
        if (on_request)
          next_state = RMC_ON;
      RMC_ON:
        if (!on_request)
        begin
          if (off_immediate)
            next_state = RMC_OFF;
          else
          begin
            next_state = RMC_DELAY;
            delay_start = 1'b1;
          end
        end
      RMC_DELAY:
        if (on_request)
        begin
          next_state = RMC_ON;
          seq_abort = 1'b1;
        end
        else if (off_immediate)
        begin
          next_state = RMC_OFF;
          seq_abort = 1'b1;
        end
        else if (delay_done || !delay_busy)
        begin
          next_state = RMC_FALL;
          fall_start = 1'b1;
        end
      RMC_FALL:
        if (on_request)
        begin
          next_state = RMC_ON;
          seq_abort = 1'b1;
        end
        else if (off_immediate || fall_done || !fall_busy)
        begin
          next_state = RMC_OFF;
          seq_abort = 1'b1;
        end
      default:
        next_state = RMC_OFF;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      state <= RMC_OFF;
    else
      state <= next_state;
  end

  // --------------------------------------------------------------
  // power stage and setpoint outputs
  // --------------------------------------------------------------
  logic [1:0] margin_code;
  logic [1:0] policy_code;
  logic [1:0] next_setpoint_select;
  logic next_output_enable;
  logic next_fall_active;
  logic next_faults_ignore;
  logic next_faults_act;

  assign margin_code = output_operation_control[OP_MARGIN_LSB +: 2];
  assign policy_code = output_operation_control[OP_FAULT_POLICY_LSB +: 2];

  always_comb
  begin
    next_output_enable = (next_state != RMC_OFF);
    next_fall_active = (next_state == RMC_FALL);
    case (margin_code)
      MARGIN_LOW: next_setpoint_select = MARGIN_LOW;
      MARGIN_HIGH: next_setpoint_select = MARGIN_HIGH;
      default: next_setpoint_select = MARGIN_NOMINAL; // unsupported 11 stays nominal
    endcase
    // unsupported policy codes raise neither flag
    next_faults_ignore = (policy_code == FAULT_POLICY_IGNORE);
    next_faults_act = (policy_code == FAULT_POLICY_ACT);
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      output_enable <= 1'b0;
      fall_active <= 1'b0;
      setpoint_select <= MARGIN_NOMINAL;
      margin_faults_ignore <= 1'b0;
      margin_faults_act <= 1'b0;
    end
    else
    begin
      output_enable <= next_output_enable;
      fall_active <= next_fall_active;
      setpoint_select <= next_setpoint_select;
      margin_faults_ignore <= next_faults_ignore;
      margin_faults_act <= next_faults_act;
    end
  end
endmodule

// ### verif/rmc_checker.sv
`timescale 1ns/1ns
// ---------------------------------------
// command port and output checks
// ---------------------------------------
module rmc_checker
  import rmc_pkg::*;
#(
  parameter int SERIAL_BYTES = 16
)(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_index,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_done,
  input wire logic cmd_err,
  input wire logic control_enable_pin,
  input wire logic output_enable,
  input wire logic fall_active,
  input wire logic [1:0] setpoint_select,
  input wire logic margin_faults_ignore,
  input wire logic margin_faults_act
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // handshake of the command port
  chk_done_after_cmd: assert property ((cmd_wr || cmd_rd) |=> cmd_done)
    else $error("no done after command");
  chk_done_no_cmd: assert property (!(cmd_wr || cmd_rd) |=> !cmd_done)
    else $error("done without command");
  chk_err_with_done: assert property (cmd_err |-> cmd_done)
    else $error("error without done");
  chk_rdata_held: assert property (!cmd_rd |=> $stable(cmd_rdata))
    else $error("read data moved without read");
  chk_serial_range: assert property (cmd_wr && cmd_code == OFS_CUSTOMER_SERIAL_BLOCK
    && cmd_index >= SERIAL_BYTES |=> cmd_err)
    else $error("serial index overflow not refused");
  chk_unknown_read: assert property (cmd_rd && !cmd_wr && cmd_code == 8'h03
    |=> cmd_err && cmd_rdata == 16'h0000)
    else $error("unmapped read not refused");
  // output decode sanity
  chk_fall_keeps_on: assert property (fall_active |-> output_enable)
    else $error("fall phase with stage off");
  chk_margin_flags: assert property (!(margin_faults_ignore && margin_faults_act))
    else $error("both margin fault flags set");
  chk_setpoint_code: assert property (setpoint_select != 2'b11)
    else $error("unsupported setpoint code");
  // an operation write lands one edge later, the decoded outputs one edge after that
  chk_margin_nominal: assert property (cmd_wr && cmd_code == OFS_OUTPUT_OPERATION_CONTROL
    && cmd_wdata[OP_MARGIN_LSB +: 2] != MARGIN_LOW && cmd_wdata[OP_MARGIN_LSB +: 2] != MARGIN_HIGH
    |-> ##2 setpoint_select == MARGIN_NOMINAL)
    else $error("nominal setpoint not selected");
  chk_margin_low: assert property (cmd_wr && cmd_code == OFS_OUTPUT_OPERATION_CONTROL
    && cmd_wdata[OP_MARGIN_LSB +: 2] == MARGIN_LOW |-> ##2 setpoint_select == MARGIN_LOW)
    else $error("low margin setpoint not selected");
  chk_margin_high: assert property (cmd_wr && cmd_code == OFS_OUTPUT_OPERATION_CONTROL
    && cmd_wdata[OP_MARGIN_LSB +: 2] == MARGIN_HIGH |-> ##2 setpoint_select == MARGIN_HIGH)
    else $error("high margin setpoint not selected");
  chk_policy_ignore: assert property (cmd_wr && cmd_code == OFS_OUTPUT_OPERATION_CONTROL
    && cmd_wdata[OP_FAULT_POLICY_LSB +: 2] == FAULT_POLICY_IGNORE |-> ##2 margin_faults_ignore)
    else $error("ignore policy not decoded");
  chk_policy_act: assert property (cmd_wr && cmd_code == OFS_OUTPUT_OPERATION_CONTROL
    && cmd_wdata[OP_FAULT_POLICY_LSB +: 2] == FAULT_POLICY_ACT |-> ##2 margin_faults_act)
    else $error("act policy not decoded");
endmodule

bind rmc_control rmc_checker #(.SERIAL_BYTES(SERIAL_BYTES)) chk (.mclk(mclk), .sys_rst(sys_rst),
  .cmd_code(cmd_code), .cmd_index(cmd_index), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata),
  .cmd_rdata(cmd_rdata), .cmd_done(cmd_done), .cmd_err(cmd_err), .control_enable_pin(control_enable_pin),
  .output_enable(output_enable), .fall_active(fall_active), .setpoint_select(setpoint_select),
  .margin_faults_ignore(margin_faults_ignore), .margin_faults_act(margin_faults_act));

// ### verif/rmc_pin_drv.sv
`timescale 1ns/1ns
// ---------------------------------------
// board-side enable pin driver
// ---------------------------------------
module rmc_pin_drv (
  input wire logic want_on,
  input wire logic active_high,
  output logic pin
);
  // bench speaks in asserted terms; the board must match the configured polarity
  assign pin = active_high ? want_on : !want_on;
endmodule

// ### verif/regulator_on_off_margin_control_test.sv
`timescale 1ns/1ns
module regulator_on_off_margin_control_test;
  import rmc_pkg::*;
  localparam int DLY = 3;
  localparam int FAL = 3;
  localparam logic [7:0] SER = OFS_CUSTOMER_SERIAL_BLOCK;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] cmd_code = 8'h00;
  logic [7:0] cmd_index = 8'h00;
  logic cmd_wr = 1'b0;
  logic cmd_rd = 1'b0;
  logic [15:0] cmd_wdata = 16'h0000;
  logic [15:0] cmd_rdata;
  logic cmd_done, cmd_err, output_enable, fall_active, margin_faults_ignore, margin_faults_act;
  logic [1:0] setpoint_select;
  logic pin_on = 1'b1;
  logic pin_pol = 1'b1;
  logic pin;
  logic [15:0] rd_val;
  logic rd_err;
  int n_mismatch = 0;
  int cmp_count = 0;

  // ---------------------------------------
  // clock, pin driver and design
  // ---------------------------------------
  always #2 mclk = ~mclk;

  rmc_pin_drv drv (.want_on(pin_on), .active_high(pin_pol), .pin(pin));

  // short turn-off counts keep sequenced cases fast
  rmc_control #(.DELAY_CYCLES(DLY), .FALL_CYCLES(FAL)) uut (.mclk(mclk), .sys_rst(sys_rst),
    .cmd_code(cmd_code), .cmd_index(cmd_index), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .cmd_done(cmd_done), .cmd_err(cmd_err), .control_enable_pin(pin),
    .output_enable(output_enable), .fall_active(fall_active), .setpoint_select(setpoint_select),
    .margin_faults_ignore(margin_faults_ignore), .margin_faults_act(margin_faults_act));

  // ---------------------------------------
  // shared tasks
  // ---------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one strobe cycle; done, data and error are taken the cycle after
  task automatic access(input logic wr, input logic [7:0] code, input logic [7:0] idx, input logic [15:0] data);
    @(posedge mclk);
    cmd_wr <= wr;
    cmd_rd <= !wr;
    cmd_code <= code;
    cmd_index <= idx;
    cmd_wdata <= data;
    @(posedge mclk);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    #1;
    check("done", 16'h0001, {15'h0000, cmd_done});
    rd_val = cmd_rdata;
    rd_err = cmd_err;
  endtask

  task automatic wop(input logic [15:0] v);
    access(1'b1, OFS_OUTPUT_OPERATION_CONTROL, 8'h00, v);
  endtask

  task automatic wcfg(input logic [15:0] v);
    access(1'b1, OFS_ON_OFF_GATING_CONFIG, 8'h00, v);
  endtask

  // bounded wait on the stage (sel 0) or fall flag (sel 1); a miss ends the run
  task automatic wait_for(input string what, input int sel, input logic exp, input int n);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < n && !seen; i++)
    begin
      @(posedge mclk);
      #1;
      seen = (((sel == 0) ? output_enable : fall_active) === exp);
    end
    check(what, 16'h0001, {15'h0000, seen});
    if (!seen)
      report_and_stop();
  endtask

  // ---------------------------------------
  // main sequence
  // ---------------------------------------
  initial
  begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    access(1'b0, OFS_OUTPUT_OPERATION_CONTROL, 8'h00, 16'h0000);
    check("op reset", 16'h0088, rd_val);
    access(1'b0, OFS_ON_OFF_GATING_CONFIG, 8'h00, 16'h0000);
    check("cfg reset", 16'h001F, rd_val);
    check("on after reset", 16'h0001, {15'h0000, output_enable});
    access(1'b1, OFS_BUS_BASE_ADDRESS_PRIMARY, 8'h00, 16'h0055);
    check("ro write err", 16'h0001, {15'h0000, rd_err});
    access(1'b0, OFS_BUS_BASE_ADDRESS_PRIMARY, 8'h00, 16'h0000);
    check("base primary", 16'h0010, rd_val);
    access(1'b0, OFS_BUS_BASE_ADDRESS_SECONDARY, 8'h00, 16'h0000);
    check("base secondary", 16'h0050, rd_val);
    access(1'b0, 8'h03, 8'h00, 16'h0000);
    check("unmapped err", 16'h0001, {15'h0000, rd_err});
    $display("test reset values done");
    // every margin and fault policy code, reserved bits written as ones
    for (int m = 0; m < 4; m++)
      for (int p = 0; p < 4; p++)
      begin
        wop({8'h00, 2'b10, m[1:0], p[1:0], 2'b11});
        access(1'b0, OFS_OUTPUT_OPERATION_CONTROL, 8'h00, 16'h0000);
        check("op readback", {8'h00, 2'b10, m[1:0], p[1:0], 2'b00}, rd_val);
        check("setpoint", {14'h0000, (m == 3) ? 2'b00 : m[1:0]}, {14'h0000, setpoint_select});
        check("ignore flag", {15'h0000, p == 1}, {15'h0000, margin_faults_ignore});
        check("act flag", {15'h0000, p == 2}, {15'h0000, margin_faults_act});
      end
    $display("test margin decode done");
    wop(16'h0008);
    wait_for("cmd off now", 0, 1'b0, 1);
    wop(16'h00C8);
    wait_for("cmd on", 0, 1'b1, 2);
    wop(16'h0048);
    wait_for("fall starts", 1, 1'b1, DLY + 3);
    check("on in fall", 16'h0001, {15'h0000, output_enable});
    wait_for("seq off", 0, 1'b0, FAL + 3);
    $display("test command off done");
    wcfg(16'h0017);
    wait_for("on bit ignored", 0, 1'b1, 2);
    wcfg(16'h001F);
    wait_for("on bit obeyed", 0, 1'b0, DLY + FAL + 6);
    wop(16'h0088);
    wait_for("back on", 0, 1'b1, 2);
    @(posedge mclk);
    pin_on <= 1'b0;
    wait_for("pin off now", 0, 1'b0, 1);
    wcfg(16'h001B);
    wait_for("pin ignored", 0, 1'b1, 2);
    wcfg(16'h001E);
    wait_for("pin seq fall", 1, 1'b1, DLY + 4);
    wait_for("pin seq off", 0, 1'b0, FAL + 3);
    $display("test gating done");
    @(posedge mclk);
    pin_pol <= 1'b0;
    pin_on <= 1'b1;
    wcfg(16'h001D);
    wait_for("low active on", 0, 1'b1, 2);
    @(posedge mclk);
    pin_on <= 1'b0;
    wait_for("low active off", 0, 1'b0, 1);
    wcfg(16'h000D);
    wop(16'h0008);
    wait_for("powerup on", 0, 1'b1, 3);
    wcfg(16'h00E0);
    access(1'b0, OFS_ON_OFF_GATING_CONFIG, 8'h00, 16'h0000);
    check("cfg reserved", 16'h0000, rd_val);
    $display("test polarity and powerup done");
    access(1'b1, SER, 8'h00, 16'h00A5);
    access(1'b1, SER, 8'h0F, 16'h005A);
    access(1'b0, SER, 8'h00, 16'h0000);
    check("serial first", 16'h00A5, rd_val & 16'h00FF);
    access(1'b0, SER, 8'h0F, 16'h0000);
    check("serial last", 16'h005A, rd_val & 16'h00FF);
    access(1'b1, SER, 8'h10, 16'h0011);
    check("serial overflow", 16'h0001, {15'h0000, rd_err});
    access(1'b0, OFS_DEVICE_IDENTIFIER_BLOCK, 8'h00, 16'h0000);
    check("device id reset", RST_DEVICE_IDENTIFIER, rd_val);
    access(1'b1, OFS_DEVICE_IDENTIFIER_BLOCK, 8'h00, 16'hC3A5);
    access(1'b0, OFS_DEVICE_IDENTIFIER_BLOCK, 8'h00, 16'h0000);
    check("device id", 16'hC3A5, rd_val);
    $display("test serial block done");
    // reset in mid-run must bring back the defaults over written values
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    check("off in reset", 16'h0000, {15'h0000, output_enable});
    sys_rst <= 1'b0;
    access(1'b0, OFS_OUTPUT_OPERATION_CONTROL, 8'h00, 16'h0000);
    check("op re-reset", 16'h0088, rd_val);
    access(1'b0, OFS_ON_OFF_GATING_CONFIG, 8'h00, 16'h0000);
    check("cfg re-reset", 16'h001F, rd_val);
    check("on after re-reset", 16'h0001, {15'h0000, output_enable});
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule
